// ==== dv/tb_top.sv ====
// self-checking bench for the instruction flow trace encoder
// assumes trace_buffer_model on the record side; bench tasks act as AXI4-Lite master
`timescale 1ns/100ps
module tb_top
  import trace_encoder_pkg::*;
;
  typedef struct packed {
    flow_kind_t       k;
    logic             c;
    logic [31:0]      pc;
    logic [LEN_W-1:0] len;
    logic [47:0]      d;
  } step_t;
  logic       clk, rst_n, traceEnableIn, debugMode, holdOff, stallPipe, recValid, recReady;
  retire_t    retire;
  user_msg_t  userMsg;
  record_t    rec;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [1:0] bresp, rresp, r;
  logic       awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int         num_errors, tests_run;
  step_t      flow [10];
  instruction_flow_trace_encoder dut (.clk(clk), .rst_n(rst_n), .traceEnableIn(traceEnableIn), .debugMode(debugMode),
    .retire(retire), .userMsg(userMsg), .stallPipe(stallPipe), .recValid(recValid), .rec(rec), .recReady(recReady),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  trace_buffer_model bufm (.clk(clk), .rst_n(rst_n), .holdOff(holdOff), .recValid(recValid), .rec(rec),
    .recReady(recReady));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // handshake decisions use values settled at the falling edge, acted on at the next rise
  task automatic axi(input bit w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] qd,
                     output logic [1:0] rs);
    bit done;
    bit sa;
    bit sw;
    done = 1'h0;
    @(posedge clk);
    if (w) {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    else {araddr, arvalid, rready} <= {a, 2'h3};
    for (int n = 0; n < 100 && !done; n++) begin
      @(negedge clk);
      sa = w ? awready : arready;
      sw = wready;
      done = w ? bvalid : rvalid;
      qd = rdata;
      rs = w ? bresp : rresp;
      @(posedge clk);
      if (sa) {awvalid, arvalid} <= 2'h0;
      if (sw && w) wvalid <= 1'h0;
      if (done) {bready, rready} <= 2'h0;
    end
    if (!done) begin
      num_errors++;
      $display("ERROR bus answer expected 1 seen 0");
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi(1'h1, a, d, q, r);
    chk("write resp", 64'(r), 64'(RESP_OKAY));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    axi(1'h0, a, 32'h0, q, r);
    chk(nm, 64'({r, q}), 64'({RESP_OKAY, e}));
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic ret(input flow_kind_t k, input logic c, input logic [31:0] pc);
    @(posedge clk);
    retire <= '{1'h1, k, c, pc};
  endtask
  task automatic idle();
    @(posedge clk);
    retire.valid <= 1'h0;
    userMsg.valid <= 1'h0;
  endtask
  task automatic msg(input logic s, input logic [31:0] d);
    @(posedge clk);
    userMsg <= '{1'h1, s, d};
    idle();
    cyc(3);
  endtask
  // an empty queue yields all ones, which never matches a record
  task automatic popRec(input string nm, input logic [LEN_W-1:0] l, input logic [47:0] d);
    record_t g;
    g = '1;
    if (bufm.got.size() > 0) g = bufm.got.pop_front();
    chk(nm, 64'(g), 64'({l, d}));
  endtask
  function automatic logic [47:0] full(input logic c, input logic [31:0] pc);
    return {12'h0, !c, pc[31:1], PFX_FULL};
  endfunction
  // hang guard
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    $display("ERROR run length expected done seen hung");
    give_verdict();
  end
  initial begin
    {rst_n, traceEnableIn, debugMode, holdOff, retire, userMsg, awaddr, wdata, awvalid, wvalid, bready,
     araddr, arvalid, rready} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    rd(OFS_CONTROL, CTL_RESET, "control reset");
    rd(OFS_CONTROL2, CTL2_RESET, "control2 reset");
    rd(OFS_STATUS, 32'h0, "status reset");
    wr(OFS_CONTROL2, 32'hFFFF_FFFF);
    rd(OFS_CONTROL2, CTL2_WMASK, "control2 fields");
    wr(OFS_CONTROL2, 32'h0);
    axi(1'h0, 8'h0C, 32'h0, q, r);
    chk("unmapped read", 64'({r, q}), 64'({RESP_DECERR, 32'h0}));
    axi(1'h1, 8'h0C, 32'h1, q, r);
    chk("unmapped write", 64'(r), 64'(RESP_DECERR));
    $display("test registers done");
    // sync count 8: a full record on every ninth traced instruction
    wr(OFS_CONTROL, 32'h0008_0000);
    flow[0] = '{FLOW_SEQ, 1'h0, 32'h0000_1000, LEN_RESUME, (full(1'h0, 32'h0000_1000) << 4) | 48'hF};
    flow[1] = '{FLOW_SEQ, 1'h0, 32'h0000_1004, LEN_SEQ, 48'h0};
    flow[2] = '{FLOW_STATIC, 1'h0, 32'h0000_2000, LEN_STATIC, 48'h1};
    flow[3] = '{FLOW_JUMP, 1'h0, 32'h0000_2040, LEN_SHORT, 48'h203};
    flow[4] = '{FLOW_JUMP, 1'h0, 32'h0000_3040, LEN_MED, 48'h800B};
    flow[5] = '{FLOW_JUMP, 1'h0, 32'h1003_0000, LEN_FULL, full(1'h0, 32'h1003_0000)};
    flow[6] = '{FLOW_SEQ, 1'h1, 32'h1003_0002, LEN_FULL, full(1'h1, 32'h1003_0002)};
    flow[7] = '{FLOW_SEQ, 1'h1, 32'h1003_0004, LEN_SEQ, 48'h0};
    flow[8] = '{FLOW_JUMP, 1'h1, 32'h1003_0000, LEN_SHORT, 48'hFE3};
    flow[9] = '{FLOW_SEQ, 1'h1, 32'h1003_0002, LEN_FULL, full(1'h1, 32'h1003_0002)};
    traceEnableIn <= 1'h1;
    foreach (flow[i]) ret(flow[i].k, flow[i].c, flow[i].pc);
    idle();
    cyc(3);
    foreach (flow[i]) popRec("flow record", flow[i].len, flow[i].d);
    chk("flow extra records", 64'(bufm.got.size()), 64'h0);
    $display("test flow done");
    debugMode <= 1'h1;
    ret(FLOW_JUMP, 1'h1, 32'h1003_0004);
    ret(FLOW_SEQ, 1'h1, 32'h1003_0006);
    ret(FLOW_SEQ, 1'h1, 32'h1003_0010);
    debugMode <= 1'h0; // leave debug in the cycle of a retire
    idle();
    cyc(3);
    popRec("debug resume", LEN_RESUME, (full(1'h1, 32'h1003_0010) << 4) | 48'hF);
    chk("debug extra records", 64'(bufm.got.size()), 64'h0);
    $display("test debug done");
    // drop without stall: the second record has nowhere to go
    holdOff <= 1'h1;
    cyc(2);
    ret(FLOW_SEQ, 1'h1, 32'h1003_0012);
    ret(FLOW_SEQ, 1'h1, 32'h1003_0014);
    idle();
    @(negedge clk);
    chk("no stall when off", 64'(stallPipe), 64'h0);
    rd(OFS_STATUS, 32'h1, "status overflow");
    holdOff <= 1'h0;
    cyc(2);
    ret(FLOW_SEQ, 1'h1, 32'h1003_0016);
    idle();
    cyc(3);
    chk("overflow records", 64'(bufm.got.size()), 64'h2);
    popRec("held record", LEN_SEQ, 48'h0);
    popRec("overflow resume", LEN_RESUME, (full(1'h1, 32'h1003_0016) << 4) | 48'hF);
    axi(1'h1, OFS_STATUS, 32'h1, q, r);
    rd(OFS_STATUS, 32'h0, "status cleared");
    $display("test overflow done");
    wr(OFS_CONTROL, 32'h0008_0001);
    holdOff <= 1'h1;
    cyc(2);
    ret(FLOW_SEQ, 1'h1, 32'h1003_0018);
    idle();
    cyc(2);
    @(negedge clk);
    chk("stall raised", 64'(stallPipe), 64'h1);
    rd(OFS_STATUS, 32'h2, "status stall");
    holdOff <= 1'h0;
    cyc(3);
    @(negedge clk);
    chk("stall released", 64'(stallPipe), 64'h0);
    chk("stall records", 64'(bufm.got.size()), 64'h1);
    bufm.got.delete();
    $display("test stall done");
    cyc(1);
    traceEnableIn <= 1'h0;
    wr(OFS_CONTROL, 32'h0008_0002);
    msg(1'h0, 32'h1234_5678);
    chk("gated message", 64'(bufm.got.size()), 64'h0);
    wr(OFS_CONTROL2, 32'h0000_0200);
    msg(1'h1, 32'hDEAD_BEEF);
    popRec("user message", LEN_UTM, {12'h0, 1'h1, 32'hDEAD_BEEF, PFX_UTM});
    traceEnableIn <= 1'h1;
    msg(1'h0, 32'h0000_0001);
    chk("message with flow on", 64'(bufm.got.size()), 64'h0);
    traceEnableIn <= 1'h0;
    wr(OFS_CONTROL, 32'h0008_0006);
    wr(OFS_CONTROL2, 32'h0000_0600);
    msg(1'h0, 32'h0000_0002);
    chk("message with delta", 64'(bufm.got[0].len), 64'(LEN_UTM_DC));
    bufm.got.delete();
    // prescale 1 ticks every other clock, so rollover needs about 2048 cycles
    cyc(1500);
    chk("early rollover", 64'(bufm.got.size()), 64'h0);
    cyc(600);
    popRec("rollover", LEN_ROLL, 48'h0);
    $display("test user messages done");
    give_verdict();
  end
endmodule

// ==== dv/trace_buffer_model.sv ====
// behavioural trace control buffer taking records from the encoder
// assumes rec/recValid registered on clk; holdOff is the bench's drain knob
`timescale 1ns/100ps
module trace_buffer_model
  import trace_encoder_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    rst_n,
  input  wire logic    holdOff,
  input  wire logic    recValid,
  input  wire record_t rec,
  output logic         recReady
);
  record_t got[$];
  // ready lags the knob a cycle, as a real drain path would
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      recReady <= 1'h0;
    end else begin
      recReady <= !holdOff;
      // bits above the record length are ignored, so they are masked
      if (recValid && recReady) begin
        got.push_back('{rec.len, rec.data & ((48'h1 << rec.len) - 48'h1)});
      end
    end
  end
endmodule

// ==== dv/trace_encoder_chk.sv ====
// assertions on the record stream and stall output of the encoder
// assumes bind onto instruction_flow_trace_encoder, single clock domain
`timescale 1ns/100ps
module trace_encoder_chk
  import trace_encoder_pkg::*;
(
  input wire logic    clk,
  input wire logic    rst_n,
  input wire logic    traceEnableIn,
  input wire logic    debugMode,
  input wire retire_t retire,
  input wire logic    stallPipe,
  input wire logic    recValid,
  input wire record_t rec,
  input wire logic    recReady
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic free;
  logic on;
  logic took;
  // a retire is only taken while the slot is free, else it is dropped
  assign free = !recValid || recReady;
  assign on   = traceEnableIn && !debugMode;
  assign took = retire.valid && on && free;
  sequence s_took(flow_kind_t k);
    took && retire.kind == k;
  endsequence
  property p_stall; stallPipe |-> recValid && !recReady; endproperty
  a_stall: assert property (p_stall) else $error("stall without blocked record");
  property p_hold; recValid && !recReady |=> recValid && $stable(rec); endproperty
  a_hold: assert property (p_hold) else $error("record changed while blocked");
  property p_quiet; free && traceEnableIn && (debugMode || !retire.valid) |=> !recValid; endproperty
  a_quiet: assert property (p_quiet) else $error("record without traced instruction");
  property p_seq; s_took(FLOW_SEQ) |=> rec.len == LEN_SEQ && rec.data == '0 || rec.len >= LEN_FULL; endproperty
  a_seq: assert property (p_seq) else $error("bad sequential record");
  property p_static; s_took(FLOW_STATIC) |=> rec.len == LEN_STATIC && rec.data == 48'h1 || rec.len >= LEN_FULL;
  endproperty
  a_static: assert property (p_static) else $error("bad static branch record");
  property p_jump; s_took(FLOW_JUMP) |=> rec.data[1:0] == 2'h3 && rec.len > LEN_STATIC; endproperty
  a_jump: assert property (p_jump) else $error("bad jump record");
  property p_full;
    took ##1 rec.len == LEN_FULL |->
      rec.data[35:0] == {!$past(retire.compressed), 31'($past(retire.pc) >> 1), PFX_FULL};
  endproperty
  a_full: assert property (p_full) else $error("bad full record");
  property p_resume;
    took ##1 rec.len == LEN_RESUME |->
      rec.data[39:0] == {!$past(retire.compressed), 31'($past(retire.pc) >> 1), PFX_FULL, PFX_RESUME};
  endproperty
  a_resume: assert property (p_resume) else $error("bad resume record");
  property p_on; took && !$past(on) |=> rec.len == LEN_RESUME; endproperty
  a_on: assert property (p_on) else $error("no resume after trace on");
  property p_short; rec.len == LEN_SHORT |-> rec.data[3:0] == PFX_SHORT && rec.data[47:12] == '0; endproperty
  a_short: assert property (p_short) else $error("bad short offset record");
endmodule
bind instruction_flow_trace_encoder trace_encoder_chk u_chk (.clk(clk), .rst_n(rst_n), .traceEnableIn(traceEnableIn),
  .debugMode(debugMode), .retire(retire), .stallPipe(stallPipe), .recValid(recValid), .rec(rec), .recReady(recReady));

// ==== rtl/instruction_flow_trace_encoder.sv ====
// instruction flow trace encoder with AXI4-Lite control registers
// assumes retire info, trace buffer and bus all on clk; core obeys stallPipe at once
// Functional notes
// - trace turning on forces a full PC record for the first traced instruction
// - stall-on-full holds the pipe while buffer busy; else overflow drops and restarts
// - stall cycles give no record; recValid low when nothing traced
// - sequential instruction is one zero bit
// - non-sequential flow uses prefix 10 or 11, attached to the target
// - taken static branch is prefix 10 without address
// - indirect jumps and interrupts are prefix 11 with address information
// - short offset record 0011 with PC delta bits 8:1 in 11:4
// - medium offset record 1011 with PC delta bits 16:1 in 19:4
// - full record 0111, PC 31:1 in 34:4, no-compression flag in 35
// - no-compression flag is 1 for standard code, 0 for compressed code
// - full record on every switch between standard and compressed code
// - sync counter runs down a software period and forces a full record
// - after any discontinuity emit resume prefix 1111 followed by a full record
// - no tracing at all while in debug mode
// - user message gate bit passes or blocks user messages
// - two-bit prescale divides clock for the delta-cycle tick
// - special modes work only while normal flow trace is off
// - PCs and offsets are virtual addresses as retired
// - messages carry ticks elapsed since the previous message
// - ten-bit delta; rollover message and clear to 0 on the tick after it reaches 1023
`timescale 1ns/100ps
module instruction_flow_trace_encoder
  import trace_encoder_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  traceEnableIn,
  input  wire logic                  debugMode,
  input  wire retire_t               retire,
  input  wire user_msg_t             userMsg,
  output logic                       stallPipe,
  output logic                       recValid,
  output record_t                    rec,
  input  wire logic                  recReady,
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]            awprot,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  input  wire logic [2:0]            arprot,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready
);

  // byte-lane merge for writable registers
  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old & ~m) | (nw & m);
  endfunction

  // true when a signed delta survives shifting down by msb bits
  function automatic logic fitsSigned(input logic [31:0] d, input int msb);
    logic [31:0] s;
    s = $unsigned($signed(d) >>> msb);
    return (s == 32'h0000_0000) || (s == 32'hFFFF_FFFF);
  endfunction

  // full-address record body
  function automatic logic [35:0] fullRec(input logic [31:0] pc, input logic comp);
    return {~comp, pc[31:1], PFX_FULL};
  endfunction

  // ---------------- bus state ----------------
  logic                  awHeld_q, awHeld_d;
  logic                  wHeld_q,  wHeld_d;
  logic [AXI_ADDR_W-1:0] awAddr_q, awAddr_d;
  logic [31:0]           wData_q,  wData_d;
  logic [3:0]            wStrb_q,  wStrb_d;
  logic                  bvalid_q, bvalid_d;
  logic [1:0]            bresp_q,  bresp_d;
  logic                  rvalid_q, rvalid_d;
  logic [31:0]           rdata_q,  rdata_d;
  logic [1:0]            rresp_q,  rresp_d;
  logic [31:0]           ctl_q,    ctl_d;
  logic [31:0]           ctl2_q,   ctl2_d;
  logic                  ovfClr;

  // ---------------- trace state ----------------
  logic                  recValid_q, recValid_d;
  record_t               rec_q,      rec_d;
  logic [31:0]           lastPc_q,   lastPc_d;
  logic                  lastComp_q, lastComp_d;
  logic                  resume_q,   resume_d;
  logic                  wasOn_q,    wasOn_d;
  logic [SYNC_W-1:0]     syncCnt_q,  syncCnt_d;
  logic [DELTA_W-1:0]    delta_q,    delta_d;
  logic [2:0]            presc_q,    presc_d;
  logic                  ovf_q,      ovf_d;

  logic                  traceOn;
  logic                  specialOk;
  logic                  illegal;
  logic                  busy;

  // control decode
  assign traceOn   = traceEnableIn & ~debugMode;
  assign specialOk = ctl_q[CTL_SPECIAL_BIT] & ~traceEnableIn & ~debugMode;
  assign illegal   = ctl_q[CTL_SPECIAL_BIT] & traceEnableIn;
  assign busy      = recValid_q & ~recReady;

  // pipeline hold while the buffer cannot take a record
  assign stallPipe = ctl_q[CTL_STALL_BIT] & busy;

  // bus handshakes come straight from held flags
  assign awready = ~awHeld_q & ~bvalid_q;
  assign wready  = ~wHeld_q & ~bvalid_q;
  assign arready = ~rvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
  assign recValid = recValid_q;
  assign rec      = rec_q;

  // register slave next state; address and data may come in either order
  always_comb begin
    awHeld_d = awHeld_q;
    wHeld_d  = wHeld_q;
    awAddr_d = awAddr_q;
    wData_d  = wData_q;
    wStrb_d  = wStrb_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    ctl_d    = ctl_q;
    ctl2_d   = ctl2_q;
    ovfClr   = 1'b0;
    if (awvalid && awready) begin
      awHeld_d = 1'b1;
      awAddr_d = awaddr;
    end
    if (wvalid && wready) begin
      wHeld_d = 1'b1;
      wData_d = wdata;
      wStrb_d = wstrb;
    end
    // commit once both halves are in hand
    if (awHeld_q && wHeld_q) begin
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = RESP_OKAY;
      case ({awAddr_q[AXI_ADDR_W-1:2], 2'b00})
        OFS_CONTROL: begin
          ctl_d = mergeStrb(ctl_q, wData_q, wStrb_q, CTL_WMASK);
        end
        OFS_CONTROL2: begin
          ctl2_d = mergeStrb(ctl2_q, wData_q, wStrb_q, CTL2_WMASK);
        end
        OFS_STATUS: begin
          ovfClr = wStrb_q[0] & wData_q[ST_OVF_BIT]; // write one to clear
        end
        default: begin
          bresp_d = RESP_DECERR;
        end
      endcase
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      case ({araddr[AXI_ADDR_W-1:2], 2'b00})
        OFS_CONTROL: begin
          rdata_d = ctl_q;
        end
        OFS_CONTROL2: begin
          rdata_d = ctl2_q;
        end
        OFS_STATUS: begin
          rdata_d[ST_OVF_BIT]     = ovf_q;
          rdata_d[ST_STALL_BIT]   = stallPipe;
          rdata_d[ST_ILLEGAL_BIT] = illegal;
        end
        default: begin
          rresp_d = RESP_DECERR;
        end
      endcase
    end
  end

  // register slave flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= '0;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
      ctl_q    <= CTL_RESET;
      ctl2_q   <= CTL2_RESET;
    end else begin
      awHeld_q <= awHeld_d;
      wHeld_q  <= wHeld_d;
      awAddr_q <= awAddr_d;
      wData_q  <= wData_d;
      wStrb_q  <= wStrb_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
      ctl_q    <= ctl_d;
      ctl2_q   <= ctl2_d;
    end
  end

  // encoder next state
  always_comb begin
    logic [31:0]       pc_offset;
    logic [2:0]        prMask;
    logic              tick;
    logic              load;
    logic              needFull;
    logic              syncDue;
    logic              dcOn;
    record_t           nr;
    pc_offset    = retire.pc - lastPc_q;
    prMask     = 3'(({1'b0, 3'h1} << ctl2_q[CTL2_PRESC_LSB +: 2]) - 4'h1);
    tick       = (presc_q & prMask) == prMask;
    dcOn       = specialOk & ctl_q[CTL_DELTA_BIT];
    load       = 1'b0;
    syncDue    = (syncCnt_q == '0);
    needFull   = 1'b0;
    nr         = '0;
    recValid_d = recValid_q;
    rec_d      = rec_q;
    lastPc_d   = lastPc_q;
    lastComp_d = lastComp_q;
    resume_d   = resume_q;
    wasOn_d    = traceOn;
    syncCnt_d  = syncCnt_q;
    delta_d    = delta_q;
    presc_d    = dcOn ? presc_q + 3'h1 : 3'h0;
    ovf_d      = ovf_q;
    if (recValid_q && recReady) begin
      recValid_d = 1'b0;
    end
    // turning on or off is a discontinuity; a restart also opens with a full PC
    if (traceOn != wasOn_q) begin
      resume_d = 1'b1;
    end
    if (traceOn && retire.valid) begin
      load       = 1'b1;
      lastPc_d   = retire.pc;
      lastComp_d = retire.compressed;
      syncCnt_d  = syncDue ? ctl_q[CTL_SYNC_LSB +: SYNC_W] : syncCnt_q - 1'b1;
      needFull   = syncDue | (retire.compressed != lastComp_q);
      resume_d   = 1'b0;
      if (resume_q || (traceOn != wasOn_q)) begin
        nr.data[39:0] = {fullRec(retire.pc, retire.compressed), PFX_RESUME};
        nr.len        = LEN_RESUME;
      end else if (needFull) begin
        nr.data[35:0] = fullRec(retire.pc, retire.compressed);
        nr.len        = LEN_FULL;
      end else begin
        case (retire.kind)
          FLOW_STATIC: begin
            nr.data[1:0] = PFX_STATIC;
            nr.len       = LEN_STATIC;
          end
          FLOW_JUMP: begin
            if (fitsSigned(pc_offset, SHORT_MSB)) begin
              nr.data[11:0] = {pc_offset[8:1], PFX_SHORT};
              nr.len        = LEN_SHORT;
            end else if (fitsSigned(pc_offset, MED_MSB)) begin
              nr.data[19:0] = {pc_offset[16:1], PFX_MED};
              nr.len        = LEN_MED;
            end else begin
              nr.data[35:0] = fullRec(retire.pc, retire.compressed);
              nr.len        = LEN_FULL;
            end
          end
          default: begin
            nr.data[0] = PFX_SEQ;
            nr.len     = LEN_SEQ;
          end
        endcase
      end
    end else if (specialOk && userMsg.valid && ctl2_q[CTL2_UMG_BIT]) begin
      // user message, with elapsed ticks when delta mode is on
      load          = 1'b1;
      nr.data[35:0] = {userMsg.second, userMsg.data, PFX_UTM};
      nr.len        = LEN_UTM;
      if (dcOn) begin
        nr.data[45:36] = delta_q;
        nr.len         = LEN_UTM_DC;
      end
      delta_d = '0;
    end else if (dcOn && tick) begin
      if (delta_q == DELTA_MAX) begin
        load         = 1'b1;
        nr.data[1:0] = PFX_ROLL;
        nr.len       = LEN_ROLL;
        delta_d      = '0;
      end else begin
        delta_d = delta_q + 1'b1;
      end
    end
    if (!dcOn) begin
      delta_d = '0;
    end
    // clear first, so a drop in the same cycle still leaves the flag set
    if (ovfClr) begin
      ovf_d = 1'b0;
    end
    // a record that meets a busy buffer is lost and tracing restarts
    if (load) begin
      if (busy) begin
        resume_d = traceOn;
        ovf_d    = 1'b1;
      end else begin
        rec_d      = nr;
        recValid_d = 1'b1;
      end
    end
  end

  // encoder flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      recValid_q <= 1'b0;
      rec_q      <= '0;
      lastPc_q   <= 32'h0000_0000;
      lastComp_q <= 1'b0;
      resume_q   <= 1'b0;
      wasOn_q    <= 1'b0;
      syncCnt_q  <= '0;
      delta_q    <= '0;
      presc_q    <= 3'h0;
      ovf_q      <= 1'b0;
    end else begin
      recValid_q <= recValid_d;
      rec_q      <= rec_d;
      lastPc_q   <= lastPc_d;
      lastComp_q <= lastComp_d;
      resume_q   <= resume_d;
      wasOn_q    <= wasOn_d;
      syncCnt_q  <= syncCnt_d;
      delta_q    <= delta_d;
      presc_q    <= presc_d;
      ovf_q      <= ovf_d;
    end
  end

endmodule

// ==== rtl/trace_encoder_pkg.sv ====
// constants and carrier types of the instruction flow trace encoder
// assumes a 32-bit register slave with 8-bit byte addresses
package trace_encoder_pkg;
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_CONTROL2 = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam int CTL_STALL_BIT   = 0;
  localparam int CTL_SPECIAL_BIT = 1;
  localparam int CTL_DELTA_BIT   = 2;
  localparam int CTL_SYNC_LSB    = 16;
  localparam int SYNC_W          = 16;
  localparam logic [31:0] CTL_RESET  = 32'h0100_0000;
  localparam logic [31:0] CTL_WMASK  = 32'hFFFF_0007;
  localparam int CTL2_UMG_BIT    = 9;
  localparam int CTL2_PRESC_LSB  = 10;
  localparam logic [31:0] CTL2_RESET = 32'h0000_0000;
  localparam logic [31:0] CTL2_WMASK = 32'h0000_0E00;
  localparam int ST_OVF_BIT      = 0;
  localparam int ST_STALL_BIT    = 1;
  localparam int ST_ILLEGAL_BIT  = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int REC_W = 48;
  localparam int LEN_W = 6;
  localparam logic       PFX_SEQ    = 1'b0;
  localparam logic [1:0] PFX_STATIC = 2'h1;
  localparam logic [3:0] PFX_SHORT  = 4'h3;
  localparam logic [3:0] PFX_MED    = 4'hB;
  localparam logic [3:0] PFX_FULL   = 4'h7;
  localparam logic [3:0] PFX_RESUME = 4'hF;
  localparam logic [1:0] PFX_ROLL   = 2'h0;
  localparam logic [2:0] PFX_UTM    = 3'h2;
  localparam logic [LEN_W-1:0] LEN_SEQ    = 6'h01;
  localparam logic [LEN_W-1:0] LEN_STATIC = 6'h02;
  localparam logic [LEN_W-1:0] LEN_SHORT  = 6'h0C;
  localparam logic [LEN_W-1:0] LEN_MED    = 6'h14;
  localparam logic [LEN_W-1:0] LEN_FULL   = 6'h24;
  localparam logic [LEN_W-1:0] LEN_RESUME = 6'h28;
  localparam logic [LEN_W-1:0] LEN_ROLL   = 6'h02;
  localparam logic [LEN_W-1:0] LEN_UTM    = 6'h24;
  localparam logic [LEN_W-1:0] LEN_UTM_DC = 6'h2E;
  localparam int SHORT_MSB = 8;
  localparam int MED_MSB   = 16;
  localparam int DELTA_W = 10;
  localparam logic [DELTA_W-1:0] DELTA_MAX = 10'h3FF;
  typedef enum logic [1:0] {FLOW_SEQ = 2'h0, FLOW_STATIC = 2'h1, FLOW_JUMP = 2'h3} flow_kind_t;
  typedef struct packed {
    logic        valid;
    flow_kind_t  kind;
    logic        compressed;
    logic [31:0] pc;
  } retire_t;
  typedef struct packed {
    logic        valid;
    logic        second;
    logic [31:0] data;
  } user_msg_t;
  typedef struct packed {
    logic [LEN_W-1:0] len;
    logic [REC_W-1:0] data;
  } record_t;
endpackage
